/* File: include/fao_pkg.sv */
// fao_pkg: constants, types and settings carrier for the frequency arrival outputs
// assumes frequencies arrive as unsigned counts of 0.1 Hz
`default_nettype none
package fao_pkg;

  localparam int unsigned FREQ_W         = 16;
  // frequency unit is 0.1 Hz, so one LSB is 100 mHz; band figures are in mHz, divided down to tenths
  localparam int unsigned FREQ_LSB_MHZ   = 100;
  localparam int unsigned EARLY_BAND_MHZ = 1500;
  localparam int unsigned LATE_BAND_MHZ  = 500;
  localparam logic [FREQ_W-1:0] EARLY_BAND = FREQ_W'(EARLY_BAND_MHZ / FREQ_LSB_MHZ);
  localparam logic [FREQ_W-1:0] LATE_BAND  = FREQ_W'(LATE_BAND_MHZ / FREQ_LSB_MHZ);

  // timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned FLAG_DELAY_MS = 60;
  localparam int unsigned FLAG_DELAY_CYC = (CLK_HZ / 1000) * FLAG_DELAY_MS;

  // terminal function codes
  localparam int unsigned NUM_TERM = 3;
  localparam logic [3:0] FN_RUN        = 4'h0;
  localparam logic [3:0] FN_AT_SPEED   = 4'h1;
  localparam logic [3:0] FN_OVER_SPEED = 4'h2;

  // reset values
  localparam logic OUT_IDLE_N = 1'b1;

  typedef struct packed {
    logic [FREQ_W-1:0] start_freq_setting;
    logic [FREQ_W-1:0] target_freq_setting;
    logic [FREQ_W-1:0] accel_on_threshold;
    logic [FREQ_W-1:0] decel_off_threshold;
  } fao_settings_s;

  typedef struct packed {
    logic run;
    logic at_speed;
    logic over_speed;
  } fao_flags_s;

endpackage
`default_nettype wire

/* File: rtl/fao_delay.sv */
// fao_delay: holds a level change back for a fixed number of cycles
// assumes input is synchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module fao_delay #(
  parameter int unsigned DELAY_CYC = 1
) (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic level_i,
  output logic      level_o
);

  localparam int unsigned CW = $clog2(DELAY_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic          level_q;
  wire           differs   = level_i != level_q;
  wire           expired   = cnt_q == CW'(DELAY_CYC - 1);

  // a change must persist for the full delay before it shows
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end
    else if (!differs)
      cnt_q <= '0;
    else if (expired)
    begin
      cnt_q   <= '0;
      level_q <= level_i;
    end
    else
      cnt_q <= cnt_q + CW'(1);
  end

  assign level_o = level_q;

endmodule
`default_nettype wire

/* File: rtl/fao_top.sv */
// fao_top: drive status flags and per-terminal output selection
// assumes run/freq/settings are synchronous to sys_clk_i, frequency in 0.1 Hz
//
// Contract
// - run flag on above start frequency
// - run flag off in stop mode
// - at-speed flag on at target frequency
// - at-speed off when output off or ramping
// - over-speed on at accel threshold accelerating
// - over-speed off below decel threshold decelerating
// - at-speed and over-speed flags turn on 1.5 Hz early; run flag has no band
// - at-speed and over-speed flags turn off 0.5 Hz late; run flag has no band
// - at-speed and over-speed flag changes delayed 60 ms; run flag only registered, not delayed
// - arrival flags drive terminals active low
// - both arrival functions routable simultaneously
// - equal over-speed thresholds work symmetrically
`timescale 1ns/1ps
`default_nettype none
module fao_top #(
  parameter int unsigned NUM_TERM       = fao_pkg::NUM_TERM,
  parameter int unsigned FLAG_DELAY_CYC = fao_pkg::FLAG_DELAY_CYC
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          run_mode_i,
  input  wire logic                          accel_i,
  input  wire logic                          decel_i,
  input  wire logic [fao_pkg::FREQ_W-1:0]    out_freq_i,
  input  wire fao_pkg::fao_settings_s        settings_i,
  input  wire logic [NUM_TERM-1:0][3:0]      term_func_i,
  output logic [NUM_TERM-1:0]                term_out_n_o,
  output fao_pkg::fao_flags_s                flags_o
);

  localparam int unsigned W = fao_pkg::FREQ_W;

  function automatic logic [W:0] add_sat(input logic [W-1:0] a, input logic [W-1:0] b);
    add_sat = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic [W:0] sub_flr(input logic [W-1:0] a, input logic [W-1:0] b);
    sub_flr = (a > b) ? {1'b0, a - b} : '0;
  endfunction

  wire [W:0] freq_x = {1'b0, out_freq_i};

  // at-speed band around the target
  wire [W:0] tgt_on_lo  = sub_flr(settings_i.target_freq_setting, fao_pkg::EARLY_BAND);
  wire [W:0] tgt_on_hi  = add_sat(settings_i.target_freq_setting, fao_pkg::EARLY_BAND);
  wire [W:0] tgt_off_lo = sub_flr(tgt_on_lo[W-1:0], fao_pkg::LATE_BAND);
  wire [W:0] tgt_off_hi = add_sat(tgt_on_hi[W-1:0], fao_pkg::LATE_BAND);
  wire       steady     = !accel_i && !decel_i;
  wire       at_on      = run_mode_i && steady
                          && freq_x >= tgt_on_lo && freq_x <= tgt_on_hi;
  wire       at_off     = !run_mode_i || !steady
                          || freq_x < tgt_off_lo || freq_x > tgt_off_hi;

  // over-speed thresholds, separate per direction
  wire [W:0] ovr_on_lvl  = sub_flr(settings_i.accel_on_threshold, fao_pkg::EARLY_BAND);
  wire [W:0] ovr_off_lvl = sub_flr(settings_i.decel_off_threshold, fao_pkg::LATE_BAND);
  wire       ovr_on      = run_mode_i && accel_i && freq_x >= ovr_on_lvl;
  wire       ovr_off     = !run_mode_i || (decel_i && freq_x < ovr_off_lvl);

  wire       run_raw     = run_mode_i
                           && out_freq_i > settings_i.start_freq_setting;

  logic at_q;
  logic at_d;
  logic ovr_q;
  logic ovr_d;

  // set-reset holds flags between crossings
  assign at_d  = at_on ? 1'b1 : (at_off ? 1'b0 : at_q);
  assign ovr_d = ovr_on ? 1'b1 : (ovr_off ? 1'b0 : ovr_q);

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      at_q  <= 1'b0;
      ovr_q <= 1'b0;
    end
    else
    begin
      at_q  <= at_d;
      ovr_q <= ovr_d;
    end
  end

  logic run_dly;
  logic at_dly;
  logic ovr_dly;

  fao_delay #(.DELAY_CYC(FLAG_DELAY_CYC)) u_dly_at (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .level_i   (at_q),
    .level_o   (at_dly)
  );

  fao_delay #(.DELAY_CYC(FLAG_DELAY_CYC)) u_dly_ovr (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .level_i   (ovr_q),
    .level_o   (ovr_dly)
  );

  logic run_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      run_q <= 1'b0;
    else
      run_q <= run_raw;
  end
  assign run_dly = run_q;

  // per-terminal selection, independent per terminal
  logic [NUM_TERM-1:0] sel_flag;
  always_comb
  begin
    for (int i = 0; i < NUM_TERM; i++)
    begin
      unique case (term_func_i[i])
        fao_pkg::FN_RUN:        sel_flag[i] = run_dly;
        fao_pkg::FN_AT_SPEED:   sel_flag[i] = at_dly;
        fao_pkg::FN_OVER_SPEED: sel_flag[i] = ovr_dly;
        default:                sel_flag[i] = 1'b0;
      endcase
    end
  end

  logic [NUM_TERM-1:0]  term_out_n_q;
  fao_pkg::fao_flags_s  flags_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      term_out_n_q <= {NUM_TERM{fao_pkg::OUT_IDLE_N}};
      flags_q      <= '0;
    end
    else
    begin
      term_out_n_q <= ~sel_flag;
      flags_q      <= '{run: run_dly, at_speed: at_dly, over_speed: ovr_dly};
    end
  end

  assign term_out_n_o = term_out_n_q;
  assign flags_o      = flags_q;

endmodule
`default_nettype wire

/* File: testbench/fao_load_model.sv */
// fao_load_model: relay coils hung on the open-collector terminals
// assumes terminals pull low to energise
`timescale 1ns/1ps
`default_nettype none
module fao_load_model (
  input  wire logic       sys_clk_i,
  input  wire logic [2:0] line_n_i,
  output logic [2:0]      energized_o
);
  always_ff @(posedge sys_clk_i) energized_o <= ~line_n_i;
endmodule
`default_nettype wire

/* File: testbench/fao_properties.sv */
// fao_properties: port checks for fao_top
// assumes FLAG_DELAY_CYC of 4 or less, so eight-cycle windows settle
`timescale 1ns/1ps
`default_nettype none
module fao_properties #(
  parameter int unsigned NUM_TERM       = 3,
  parameter int unsigned FLAG_DELAY_CYC = 4
) (
  input wire logic                     sys_clk_i,
  input wire logic                     resetn_i,
  input wire logic                     run_mode_i,
  input wire logic                     accel_i,
  input wire logic                     decel_i,
  input wire logic [15:0]              out_freq_i,
  input wire fao_pkg::fao_settings_s   settings_i,
  input wire logic [NUM_TERM-1:0][3:0] term_func_i,
  input wire logic [NUM_TERM-1:0]      term_out_n_o,
  input wire fao_pkg::fao_flags_s      flags_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic                   steady = run_mode_i && !accel_i && !decel_i;
  wire fao_pkg::fao_settings_s cfg    = settings_i;
  a_run_level:
    assert property (##2 1 |-> flags_o.run == $past(run_mode_i && out_freq_i > cfg.start_freq_setting, 2))
    else $error("run flag");
  a_at_on:
    assert property ((steady && out_freq_i + 15 >= cfg.target_freq_setting
      && out_freq_i <= cfg.target_freq_setting + 15) [*8] |-> flags_o.at_speed)
    else $error("at-speed on");
  a_at_ramp:
    assert property ((accel_i || decel_i) [*8] |-> !flags_o.at_speed) else $error("at-speed ramp");
  a_at_rise:
    assert property ($rose(flags_o.at_speed) |-> $past(steady, 3)) else $error("at-speed rise");
  a_over_on:
    assert property ((run_mode_i && accel_i && out_freq_i + 15 >= cfg.accel_on_threshold) [*8]
      |-> flags_o.over_speed) else $error("over-speed on");
  a_over_off:
    assert property ((decel_i && !accel_i && out_freq_i + 5 < cfg.decel_off_threshold) [*8]
      |-> !flags_o.over_speed) else $error("over-speed off");
  a_stop_idle:
    assert property (!run_mode_i [*8] |-> flags_o == 3'h0) else $error("flags in stop");
  for (genvar i = 0; i < NUM_TERM; i++)
  begin : g_term
    a_term_sel:
      assert property ($stable(term_func_i[i]) |-> term_out_n_o[i] == !(term_func_i[i] == 4'h0 ? flags_o.run
        : term_func_i[i] == 4'h1 ? flags_o.at_speed : term_func_i[i] == 4'h2 && flags_o.over_speed))
      else $error("terminal select");
  end
endmodule
bind fao_top fao_properties #(.NUM_TERM(NUM_TERM), .FLAG_DELAY_CYC(FLAG_DELAY_CYC)) props_u (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .run_mode_i(run_mode_i), .accel_i(accel_i), .decel_i(decel_i),
  .out_freq_i(out_freq_i), .settings_i(settings_i), .term_func_i(term_func_i), .term_out_n_o(term_out_n_o),
  .flags_o(flags_o));
`default_nettype wire

/* File: testbench/test_frequency_arrival_outputs.sv */
// test_frequency_arrival_outputs: random and corner runs of fao_top
// assumes delay shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module test_frequency_arrival_outputs;
  logic                   clk = 0, rst_n = 0, run = 0, acc = 0, dec = 0;
  logic [15:0]            freq = '0;
  fao_pkg::fao_settings_s set = {16'h0014, 16'h01f4, 16'h0258, 16'h0226};
  logic [2:0][3:0]        fn = {4'h2, 4'h1, 4'h0};
  logic [2:0]             term_n, coil;
  fao_pkg::fao_flags_s    flg, exp_f = '0;
  int                     bad_count = 0, total_checks = 0, cyc = 0;
  fao_top #(.NUM_TERM(3), .FLAG_DELAY_CYC(4)) dut_u (.sys_clk_i(clk), .resetn_i(rst_n), .run_mode_i(run),
    .accel_i(acc), .decel_i(dec), .out_freq_i(freq), .settings_i(set), .term_func_i(fn), .term_out_n_o(term_n),
    .flags_o(flg));
  fao_load_model load_u (.sys_clk_i(clk), .line_n_i(term_n), .energized_o(coil));
  initial forever #25 clk = ~clk;
  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic fao_pkg::fao_flags_s nxt(input fao_pkg::fao_flags_s p);
    logic st;
    st = run && !acc && !dec;
    nxt.run = run && freq > set.start_freq_setting;
    nxt.at_speed = (st && freq + 15 >= set.target_freq_setting && freq <= set.target_freq_setting + 15)
      || (p.at_speed && st && freq + 20 >= set.target_freq_setting && freq <= set.target_freq_setting + 20);
    nxt.over_speed = (run && acc && freq + 15 >= set.accel_on_threshold)
      || (p.over_speed && run && !(dec && freq + 5 < set.decel_off_threshold));
  endfunction
  function automatic logic [2:0] exp_n(input fao_pkg::fao_flags_s f);
    for (int i = 0; i < 3; i++)
      exp_n[i] = !(fn[i] == 4'h0 ? f.run : fn[i] == 4'h1 ? f.at_speed : fn[i] == 4'h2 && f.over_speed);
  endfunction
  task automatic seg();
    exp_f = nxt(exp_f);
    repeat (10) @(posedge clk);
    #1;
    check(flg, exp_f);
    check(term_n, exp_n(exp_f));
    check(coil, ~exp_n(exp_f));
  endtask
  initial
  begin
    void'($urandom(32'hc7fc_4766));
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    check(flg, 3'h0);
    check(term_n, 3'h7);
    run = 1;
    freq = 16'h0014;
    seg();
    freq = 16'h01f4;
    seg();
    acc = 1;
    repeat (2) @(posedge clk);
    #1 acc = 0;
    seg();
    acc = 1;
    repeat (4) @(posedge clk);
    #1 check(flg, 3'h6);
    seg();
    for (int k = 0; k < 150; k++)
    begin
      run = ($urandom % 5) != 0;
      {acc, dec} = 2'($urandom);
      freq = 16'(16'h01cc + $urandom % 200);
      fn[0] = 4'($urandom % 4);
      if (k == 100)
        set.decel_off_threshold = set.accel_on_threshold;
      seg();
    end
    stop_test();
  end
endmodule
`default_nettype wire
